//--- common/mpvs_pkg.sv
/*
  Package for the measurement and path view select register bank.
  Assumes a single 125 MHz system clock and a simple strobe register port.
*/
package mpvs_pkg;

  localparam int          MPVS_AW             = 8;
  localparam int          MPVS_DW             = 8;
  localparam int          MPVS_CHANNELS       = 14;
  localparam logic [7:0]  MPVS_SEL_OFFSET     = 8'h4b;
  localparam logic [7:0]  MPVS_MEAS_OFFSET    = 8'h4c;
  localparam logic [7:0]  MPVS_SHARED_OFFSET  = 8'h0a;
  localparam logic [7:0]  MPVS_REFSEL_FIRST   = 8'h18;
  localparam logic [7:0]  MPVS_REFSEL_LAST    = 8'h1e;
  localparam logic [7:0]  MPVS_SEL_RESET      = 8'h00;
  localparam logic [7:0]  MPVS_MEAS_RESET     = 8'h00;
  localparam int          MPVS_PATH_BIT       = 4;
  localparam logic [3:0]  MPVS_CHAN_NONE      = 4'h0;
  localparam logic [3:0]  MPVS_CHAN_FIRST     = 4'h1;
  localparam logic [3:0]  MPVS_CHAN_LAST      = 4'he;
  localparam logic [7:0]  MPVS_UNMAPPED_READ  = 8'h00;

  typedef struct packed {
    logic [MPVS_AW-1:0] addr;
    logic [MPVS_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } mpvs_req_t;

  typedef struct packed {
    logic       path_aux;
    logic [3:0] chan;
  } mpvs_sel_t;

endpackage

//--- rtl/mpvs_sync3.sv
/*
  Three-stage synchroniser with agreement filter for one pin-side bit.
  Assumes the input is asynchronous to ref_clk_i.
*/
`timescale 1ns/100ps
module mpvs_sync3
  import mpvs_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } mpvs_sync_st_t;

  mpvs_sync_st_t st_r;
  mpvs_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;

endmodule

//--- rtl/mpvs_chan_mux.sv
/*
  Selects the measurement value of one of the input channels.
  Assumes channel results arrive packed, channel one in the lowest byte.
*/
`timescale 1ns/100ps
module mpvs_chan_mux
  import mpvs_pkg::*;
#(
  parameter int CHANNELS = MPVS_CHANNELS
) (
  input  wire logic [CHANNELS*8-1:0] meas_i,
  input  wire logic [3:0]            chan_i,
  output logic      [7:0]            meas_o
);

  always_comb begin
    meas_o = MPVS_MEAS_RESET;
    for (int k = 1; k <= CHANNELS; k++) begin
      if (chan_i == 4'(k)) begin
        meas_o = meas_i[(k-1)*8 +: 8];
      end
    end
  end

endmodule

//--- rtl/mpvs_top.sv
/*
  Measurement and path view select register with path-steered shared view.
  Assumes frequency monitors and both timing paths present their registers
  as inputs, and a strobe-based register port on the same clock.
*/
`timescale 1ns/100ps
module mpvs_top
  import mpvs_pkg::*;
#(
  parameter int CHANNELS = MPVS_CHANNELS
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [MPVS_AW-1:0]    addr_i,
  input  wire logic [MPVS_DW-1:0]    wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic [CHANNELS*8-1:0] chan_meas_i,
  input  wire logic                  meas_valid_i,
  input  wire logic [MPVS_DW-1:0]    main_shared_i,
  input  wire logic [MPVS_DW-1:0]    aux_shared_i,
  output logic      [MPVS_DW-1:0]    rdata_o,
  output logic                       path_aux_o,
  output logic      [3:0]            meas_chan_o
);

  typedef struct packed {
    mpvs_sel_t  sel;
    logic [7:0] meas;
    logic [7:0] rdata;
  } mpvs_st_t;

  mpvs_st_t   st_r;
  mpvs_st_t   st_nxt;
  mpvs_req_t  req;
  logic [7:0] mux_meas;
  logic       valid_sync;
  logic       in_shared;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  mpvs_sync3 u_valid_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (meas_valid_i),
    .q_o       (valid_sync)
  );

  mpvs_chan_mux #(
    .CHANNELS (CHANNELS)
  ) u_mux (
    .meas_i (chan_meas_i),
    .chan_i (st_r.sel.chan),
    .meas_o (mux_meas)
  );

  assign in_shared = (req.addr == MPVS_SHARED_OFFSET) ||
                     ((req.addr >= MPVS_REFSEL_FIRST) && (req.addr <= MPVS_REFSEL_LAST));

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = MPVS_UNMAPPED_READ;
    if (req.wr && (req.addr == MPVS_SEL_OFFSET)) begin
      st_nxt.sel.path_aux = req.wdata[MPVS_PATH_BIT];
      st_nxt.sel.chan     = req.wdata[3:0];
    end
    if (st_r.sel.chan == MPVS_CHAN_NONE || st_r.sel.chan > 4'(CHANNELS)) begin
      st_nxt.meas = MPVS_MEAS_RESET;
    end else if (valid_sync) begin
      st_nxt.meas = mux_meas;
    end
    if (req.rd) begin
      if (req.addr == MPVS_SEL_OFFSET) begin
        st_nxt.rdata = {3'h0, st_r.sel.path_aux, st_r.sel.chan};
      end else if (req.addr == MPVS_MEAS_OFFSET) begin
        st_nxt.rdata = st_r.meas;
      end else if (in_shared) begin
        st_nxt.rdata = st_r.sel.path_aux ? aux_shared_i : main_shared_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '{sel: '{path_aux: 1'b0, chan: MPVS_CHAN_NONE}, meas: MPVS_MEAS_RESET,
                rdata: MPVS_SEL_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o     = st_r.rdata;
  assign path_aux_o  = st_r.sel.path_aux;
  assign meas_chan_o = st_r.sel.chan;

  property p_sel_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == MPVS_SEL_OFFSET) |=> (path_aux_o == $past(wdata_i[4]) && meas_chan_o == $past(wdata_i[3:0]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("Select write not stored.");

  property p_sel_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == MPVS_SEL_OFFSET) |=> (rdata_o[7:5] == 3'h0 && rdata_o[4:0] == $past({path_aux_o, meas_chan_o}));
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("Select readback wrong.");

  property p_refsel_view;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i >= MPVS_REFSEL_FIRST && addr_i <= MPVS_REFSEL_LAST)
        |=> rdata_o == ($past(path_aux_o) ? $past(aux_shared_i) : $past(main_shared_i));
  endproperty
  a_refsel_view: assert property (p_refsel_view) else $error("Reference selection view wrong path.");

  property p_shared_view;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == MPVS_SHARED_OFFSET && !path_aux_o) |=> rdata_o == $past(main_shared_i);
  endproperty
  a_shared_view: assert property (p_shared_view) else $error("Shared view not main path.");

  property p_no_chan;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (meas_chan_o == MPVS_CHAN_NONE) [*2] |-> st_r.meas == MPVS_MEAS_RESET;
  endproperty
  a_no_chan: assert property (p_no_chan) else $error("Measurement present with no channel.");

  property p_chan_pick;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (meas_chan_o >= MPVS_CHAN_FIRST && meas_chan_o <= MPVS_CHAN_LAST && valid_sync)
        |=> st_r.meas == $past(chan_meas_i[(meas_chan_o-1)*8 +: 8]);
  endproperty
  a_chan_pick: assert property (p_chan_pick) else $error("Wrong channel measured.");

  property p_meas_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == MPVS_MEAS_OFFSET) |=> rdata_o == $past(st_r.meas);
  endproperty
  a_meas_read: assert property (p_meas_read) else $error("Measurement readback wrong.");

  property p_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !(wr_i && addr_i == MPVS_SEL_OFFSET) |=> $stable({path_aux_o, meas_chan_o});
  endproperty
  a_hold: assert property (p_hold) else $error("Select changed without write.");

  property p_rdata_idle;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !rd_i
        |=> rdata_o == MPVS_UNMAPPED_READ;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data present without read.");

  property p_unmapped_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i != MPVS_SEL_OFFSET && addr_i != MPVS_MEAS_OFFSET && addr_i != MPVS_SHARED_OFFSET &&
       (addr_i < MPVS_REFSEL_FIRST || addr_i > MPVS_REFSEL_LAST)) |=> rdata_o == MPVS_UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

  property p_shared_aux;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == MPVS_SHARED_OFFSET && path_aux_o)
        |=> rdata_o == $past(aux_shared_i);
  endproperty
  a_shared_aux: assert property (p_shared_aux) else $error("Shared view not auxiliary path.");

  property p_refsel_main;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i >= MPVS_REFSEL_FIRST && addr_i <= MPVS_REFSEL_LAST && !path_aux_o)
        |=> rdata_o == $past(main_shared_i);
  endproperty
  a_refsel_main: assert property (p_refsel_main) else $error("Reference selection not main path.");

  property p_refsel_aux;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i >= MPVS_REFSEL_FIRST && addr_i <= MPVS_REFSEL_LAST && path_aux_o)
        |=> rdata_o == $past(aux_shared_i);
  endproperty
  a_refsel_aux: assert property (p_refsel_aux) else $error("Reference selection not auxiliary path.");

  property p_refsel_above;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == MPVS_REFSEL_LAST + 8'h01)
        |=> rdata_o == MPVS_UNMAPPED_READ;
  endproperty
  a_refsel_above: assert property (p_refsel_above) else $error("Steered view above its range.");

  property p_refsel_below;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == MPVS_REFSEL_FIRST - 8'h01)
        |=> rdata_o == MPVS_UNMAPPED_READ;
  endproperty
  a_refsel_below: assert property (p_refsel_below) else $error("Steered view below its range.");

  property p_chan_high;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (meas_chan_o > MPVS_CHAN_LAST) [*2]
        |-> st_r.meas == MPVS_MEAS_RESET;
  endproperty
  a_chan_high: assert property (p_chan_high) else $error("Measurement present for unused code.");

  property p_meas_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (!valid_sync && meas_chan_o >= MPVS_CHAN_FIRST && meas_chan_o <= MPVS_CHAN_LAST)
        |=> $stable(st_r.meas);
  endproperty
  a_meas_hold: assert property (p_meas_hold) else $error("Measurement moved while not valid.");

  property p_meas_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !valid_sync
        |=> ($stable(st_r.meas) || st_r.meas == MPVS_MEAS_RESET);
  endproperty
  a_meas_gate: assert property (p_meas_gate) else $error("Measurement taken while not valid.");

  property p_sel_write_aux;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == MPVS_SEL_OFFSET && wdata_i[4])
        |=> path_aux_o;
  endproperty
  a_sel_write_aux: assert property (p_sel_write_aux) else $error("Auxiliary view not selected.");

  property p_sel_write_main;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == MPVS_SEL_OFFSET && !wdata_i[4])
        |=> !path_aux_o;
  endproperty
  a_sel_write_main: assert property (p_sel_write_main) else $error("Main view not selected.");

  property p_other_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i != MPVS_SEL_OFFSET)
        |=> $stable({path_aux_o, meas_chan_o});
  endproperty
  a_other_write: assert property (p_other_write) else $error("Select changed by other write.");

  property p_zero_chan_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == MPVS_SEL_OFFSET && wdata_i[3:0] == MPVS_CHAN_NONE)
        |=> ##1 st_r.meas == MPVS_MEAS_RESET;
  endproperty
  a_zero_chan_write: assert property (p_zero_chan_write) else $error("Code zero still measures.");

  property p_read_fresh;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == MPVS_SEL_OFFSET) ##1 (rd_i && addr_i == MPVS_SEL_OFFSET)
        |=> rdata_o[4:0] == $past(wdata_i[4:0], 2);
  endproperty
  a_read_fresh: assert property (p_read_fresh) else $error("Read after write not fresh.");

  property p_chan_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == MPVS_SEL_OFFSET)
        |=> meas_chan_o == $past(wdata_i[3:0]);
  endproperty
  a_chan_write: assert property (p_chan_write) else $error("Channel field not stored.");

  property p_no_chan_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (meas_chan_o == MPVS_CHAN_NONE) [*2] ##0 (rd_i && addr_i == MPVS_MEAS_OFFSET)
        |=> rdata_o == MPVS_MEAS_RESET;
  endproperty
  a_no_chan_read: assert property (p_no_chan_read) else $error("Result read not zero with no channel.");

  property p_hold_path;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !(wr_i && addr_i == MPVS_SEL_OFFSET)
        |=> $stable(path_aux_o);
  endproperty
  a_hold_path: assert property (p_hold_path) else $error("View changed without write.");

  property p_hold_chan;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !(wr_i && addr_i == MPVS_SEL_OFFSET)
        |=> $stable(meas_chan_o);
  endproperty
  a_hold_chan: assert property (p_hold_chan) else $error("Channel changed without write.");

  property p_write_no_read;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_i && !rd_i)
        |=> rdata_o == MPVS_UNMAPPED_READ;
  endproperty
  a_write_no_read: assert property (p_write_no_read) else $error("Write produced read data.");

endmodule

//--- test/mpvs_bench.sv
/*
  Self-checking bench for the measurement and path view select register.
  Assumes the design package and mpvs_top are compiled first.
*/
`timescale 1ns/100ps
module mpvs_bench;
  import mpvs_pkg::*;
  logic             ref_clk_i;
  logic             sys_rst_i;
  logic [7:0]       addr_i;
  logic [7:0]       wdata_i;
  logic             wr_i;
  logic             rd_i;
  logic [14*8-1:0]  chan_meas_i;
  logic             meas_valid_i;
  logic [7:0]       main_shared_i;
  logic [7:0]       aux_shared_i;
  logic [7:0]       rdata_o;
  logic             path_aux_o;
  logic [3:0]       meas_chan_o;
  logic [7:0]       d;
  int               mismatches;
  int               n_tests;
  int               cyc;

  mpvs_top #(.CHANNELS(14)) dut_u (
    .ref_clk_i     (ref_clk_i),
    .sys_rst_i     (sys_rst_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .chan_meas_i   (chan_meas_i),
    .meas_valid_i  (meas_valid_i),
    .main_shared_i (main_shared_i),
    .aux_shared_i  (aux_shared_i),
    .rdata_o       (rdata_o),
    .path_aux_o    (path_aux_o),
    .meas_chan_o   (meas_chan_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  // Cuts a hang short; the run needs well under 1000 cycles.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    sys_rst_i     = 1'b1;
    addr_i        = 8'h00;
    wdata_i       = 8'h00;
    wr_i          = 1'b0;
    rd_i          = 1'b0;
    meas_valid_i  = 1'b1;
    main_shared_i = 8'h5a;
    aux_shared_i  = 8'ha5;
    for (int k = 0; k < 14; k++) chan_meas_i[k*8 +: 8] = 8'(17 * (k + 1));
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(MPVS_SEL_OFFSET, d);
    chk("sel_reset", d, 8'h00);
    chk("path_reset", {7'h00, path_aux_o}, 8'h00);
    wr_reg(MPVS_SEL_OFFSET, 8'hf3);
    chk("path_out", {7'h00, path_aux_o}, 8'h01);
    chk("chan_out", {4'h0, meas_chan_o}, 8'h03);
    rd_reg(MPVS_SEL_OFFSET, d);
    chk("sel_readback", d, 8'h13);
    wr_reg(8'h4a, 8'hff);
    rd_reg(MPVS_SEL_OFFSET, d);
    chk("sel_kept", d, 8'h13);
    for (int p = 1; p >= 0; p--) begin
      wr_reg(MPVS_SEL_OFFSET, 8'(p * 16));
      for (int i = 0; i < 8; i++) begin
        rd_reg((i == 0) ? MPVS_SHARED_OFFSET : 8'(MPVS_REFSEL_FIRST + i - 1), d);
        chk("shared_view", d, (p == 1) ? aux_shared_i : main_shared_i);
      end
    end
    for (int c = 0; c < 16; c++) begin
      wr_reg(MPVS_SEL_OFFSET, 8'(c));
      repeat (5) @(posedge ref_clk_i);
      rd_reg(MPVS_MEAS_OFFSET, d);
      chk("meas_result", d, (c == 15) ? 8'h00 : 8'(17 * c));
    end
    wr_reg(MPVS_SEL_OFFSET, 8'h02);
    repeat (5) @(posedge ref_clk_i);
    meas_valid_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    wr_reg(MPVS_SEL_OFFSET, 8'h05);
    repeat (5) @(posedge ref_clk_i);
    rd_reg(MPVS_MEAS_OFFSET, d);
    chk("meas_held", d, 8'h22);
    meas_valid_i <= 1'b1;
    rd_reg(8'h7f, d);
    chk("unmapped", d, MPVS_UNMAPPED_READ);
    @(posedge ref_clk_i);
    #1 chk("rdata_idle", rdata_o, 8'h00);
    wr_reg(MPVS_SEL_OFFSET, 8'h1e);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(MPVS_SEL_OFFSET, d);
    chk("sel_rereset", d, 8'h00);
    wrap_up();
  end
endmodule
